// ===== core/gate_ctrl_regs.vh
`ifndef GATE_CTRL_REGS_VH
`define GATE_CTRL_REGS_VH

// ========================================
// Timing
`define CLK_PERIOD_PS 4000
`define BLANK_TIME_PS 300000
`define SS_TIME_US 2000
`define PROT_DELAY_US 56000
`define BLANK_CYCLES ((`BLANK_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Divide first: the product would overflow 32-bit arithmetic
`define SS_CYCLES (`SS_TIME_US * (1000000 / `CLK_PERIOD_PS))
`define PROT_CYCLES (`PROT_DELAY_US * (1000000 / `CLK_PERIOD_PS))
`define PERIOD_CYCLES 3846
`define DUTY_NUM 3
`define DUTY_DEN 4

// ========================================
// Run states
`define ST_OFF 2'h0
`define ST_RUN 2'h1
`define ST_LATCH 2'h2
`endif

// ===== core/sync2.v
`timescale 1ns/1ns
module sync2 #(
    parameter W = 1
) (
    input wire core_clk,
    input wire arst_n,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_q;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ===== core/hold_timer.v
`timescale 1ns/1ns
// Counts cycles while cond holds; restarts when cond drops
module hold_timer #(
    parameter W = 26,
    parameter [W-1:0] LIMIT = 1
) (
    input wire core_clk,
    input wire arst_n,
    input wire clr,
    input wire cond,
    output reg expired_q
);
    reg [W-1:0] cnt_q;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= {W{1'b0}};
            expired_q <= 1'b0;
        end else if (clr || !cond) begin
            cnt_q <= {W{1'b0}};
            expired_q <= 1'b0;
        end else if (cnt_q >= LIMIT) begin
            expired_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ===== core/flyback_gate_control.v
`timescale 1ns/1ns
`include "gate_ctrl_regs.vh"
module flyback_gate_control #(
    parameter PW = 12,
    parameter [PW-1:0] PERIOD = `PERIOD_CYCLES,
    parameter SW = 20,
    parameter [SW-1:0] SS_LEN = `SS_CYCLES,
    parameter TW = 26,
    parameter [TW-1:0] PROT_LEN = `PROT_CYCLES
) (
    // Clock and reset
    input wire core_clk,
    input wire arst_n,
    // Supply comparators
    input wire supply_on,
    input wire supply_off,
    input wire supply_ov,
    // Loop comparators
    input wire cs_limit,
    input wire pwm_cmp,
    input wire fb_light_load,
    input wire fb_open_loop,
    input wire out_low,
    // Faults
    input wire over_temp,
    input wire frequency_set_pin_short,
    input wire frequency_set_pin_open,
    input wire cs_pin_open,
    input wire fb_pin_short,
    // Gate drive and status
    output reg gate_q,
    output reg running_q,
    output reg [SW-1:0] cs_ref_q,
    output reg overload_protect_q,
    output reg supply_overvoltage_protect_q,
    output reg over_temp_latch_q
);
    localparam integer MAX_ON_I = (PERIOD * `DUTY_NUM) / `DUTY_DEN;
    localparam integer BLANK_I = `BLANK_CYCLES;
    localparam [PW-1:0] MAX_ON = MAX_ON_I[PW-1:0];
    localparam [PW-1:0] BLANK = BLANK_I[PW-1:0];
    localparam [PW-1:0] ONE_P = 1;
    localparam [SW-1:0] ONE_S = 1;

    wire [12:0] raw = {supply_on, supply_off, supply_ov, cs_limit, pwm_cmp,
        fb_light_load, fb_open_loop, out_low, over_temp, frequency_set_pin_short,
        frequency_set_pin_open, cs_pin_open, fb_pin_short};
    wire [12:0] s;

    // ========================================
    // Input synchronisation
    sync2 #(
        .W(13)
    ) u_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .d(raw),
        .q(s)
    );

    wire on_s = s[12];
    wire off_s = s[11];
    wire ov_s = s[10];
    wire csl_s = s[9];
    wire pwm_s = s[8];
    wire light_s = s[7];
    wire open_s = s[6];
    wire low_s = s[5];
    wire ot_s = s[4];
    wire pin_fault = |s[3:0];

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg on_prev_q;
    reg [PW-1:0] phase_q;
    reg [PW-1:0] on_cnt_q;
    reg cycle_done_q;
    reg [SW-1:0] ss_cnt_q;
    wire restart = on_s && !on_prev_q;
    wire open_exp;
    wire low_exp;

    // ========================================
    // Overload timers
    hold_timer #(
        .W(TW),
        .LIMIT(PROT_LEN)
    ) u_open_timer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clr(state_q != `ST_RUN),
        .cond(open_s),
        .expired_q(open_exp)
    );

    hold_timer #(
        .W(TW),
        .LIMIT(PROT_LEN)
    ) u_low_timer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clr(state_q != `ST_RUN),
        .cond(low_s),
        .expired_q(low_exp)
    );

    wire trip_ovp = ov_s;
    wire trip_otp = ot_s;
    wire trip_olp = open_exp || low_exp;

    // ========================================
    // Run state
    always @* begin
        state_d = state_q;
        case (state_q)
            `ST_OFF: begin
                if (restart && !off_s) begin
                    state_d = `ST_RUN;
                end
            end
            `ST_RUN: begin
                if (off_s) begin
                    state_d = `ST_OFF;
                end else if (trip_ovp || trip_otp || trip_olp) begin
                    state_d = `ST_LATCH;
                end
            end
            `ST_LATCH: begin
                // Leaves through lockout, or a fresh supply-on edge while the temperature latch is clear
                if (off_s) begin
                    state_d = `ST_OFF;
                end else if (restart && !over_temp_latch_q) begin
                    state_d = `ST_RUN;
                end
            end
            default: begin
                state_d = `ST_OFF;
            end
        endcase
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= `ST_OFF;
            on_prev_q <= 1'b0;
            overload_protect_q <= 1'b0;
            supply_overvoltage_protect_q <= 1'b0;
            over_temp_latch_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            state_q <= state_d;
            on_prev_q <= on_s;
            running_q <= (state_d == `ST_RUN);
            if (state_d == `ST_RUN || state_d == `ST_OFF) begin
                // Each restart re-evaluates every fault afresh
                overload_protect_q <= 1'b0;
                supply_overvoltage_protect_q <= 1'b0;
                over_temp_latch_q <= 1'b0;
            end else if (state_q == `ST_RUN) begin
                overload_protect_q <= trip_olp;
                supply_overvoltage_protect_q <= trip_ovp;
                over_temp_latch_q <= trip_otp;
            end
        end
    end

    // ========================================
    // Soft start ramp of the current reference
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ss_cnt_q <= {SW{1'b0}};
            cs_ref_q <= {SW{1'b0}};
        end else if (state_q != `ST_RUN) begin
            ss_cnt_q <= {SW{1'b0}};
            cs_ref_q <= {SW{1'b0}};
        end else if (ss_cnt_q < SS_LEN) begin
            ss_cnt_q <= ss_cnt_q + ONE_S;
            cs_ref_q <= ss_cnt_q + ONE_S;
        end
    end

    wire ss_active = ss_cnt_q < SS_LEN;
    // Pulse ends when on-time reaches the ramped share of the max on-time
    // Products held at full width so any PW and SW pairing works
    wire [PW+SW-1:0] ss_lhs = on_cnt_q * SS_LEN;
    wire [PW+SW-1:0] ss_rhs = MAX_ON * ss_cnt_q;
    wire ss_limit = ss_active && (ss_lhs >= ss_rhs);

    // ========================================
    // Switching period and gate
    // Overload trip drops the gate in the same edge the latch is taken
    wire gate_allowed = (state_q == `ST_RUN) && !off_s && !trip_ovp && !trip_otp &&
        !trip_olp && !pin_fault && !light_s;
    wire blanked = on_cnt_q < BLANK;
    wire end_pulse = (on_cnt_q >= MAX_ON - ONE_P) ||
        (!blanked && (pwm_s || csl_s)) ||
        (!blanked && ss_limit);

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= {PW{1'b0}};
            on_cnt_q <= {PW{1'b0}};
            cycle_done_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            if (phase_q >= PERIOD - ONE_P) begin
                phase_q <= {PW{1'b0}};
                on_cnt_q <= {PW{1'b0}};
                cycle_done_q <= 1'b0;
                gate_q <= gate_allowed;
            end else begin
                phase_q <= phase_q + ONE_P;
                if (gate_q) begin
                    on_cnt_q <= on_cnt_q + ONE_P;
                end
                if (!gate_allowed || (gate_q && end_pulse)) begin
                    gate_q <= 1'b0;
                    cycle_done_q <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== dv/flyback_gate_chk.sv
`timescale 1ns/1ns
// ========================================
// Gate protection checker
module flyback_gate_chk #(
    parameter PW = 12,
    parameter [PW-1:0] PERIOD = 1,
    parameter TW = 26,
    parameter [TW-1:0] PROT_LEN = 1
) (
    // Clock and reset
    input wire core_clk,
    input wire arst_n,
    // Comparators
    input wire supply_off, supply_ov, cs_limit, fb_light_load, fb_open_loop, out_low,
    input wire over_temp, frequency_set_pin_short, frequency_set_pin_open,
    input wire cs_pin_open, fb_pin_short,
    // Outputs
    input wire gate_q, running_q, overload_protect_q,
    input wire supply_overvoltage_protect_q, over_temp_latch_q
);
    wire pin_fault = frequency_set_pin_short | frequency_set_pin_open | cs_pin_open | fb_pin_short;
    wire calm = !(pin_fault | supply_off | supply_ov | over_temp | fb_light_load |
        fb_open_loop | out_low);
    wire shut = !running_q | supply_overvoltage_protect_q | over_temp_latch_q | overload_protect_q;
    reg [15:0] on_q;
    reg [5:0] calm_q;
    reg [TW-1:0] hold_q;
    // Run lengths feed the width and delay bounds
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            on_q <= 16'h0000;
            calm_q <= 6'h00;
            hold_q <= {TW{1'b0}};
        end else begin
            on_q <= gate_q ? on_q + 16'h0001 : 16'h0000;
            calm_q <= {calm_q[4:0], calm};
            hold_q <= (fb_open_loop | out_low) ? hold_q + 1'b1 : {TW{1'b0}};
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    AST_MAX_ON: assert property (on_q <= PERIOD * 3 / 4)
        else $error("gate pulse beyond max duty");
    // Fault-free pulses may only end once blanking is over
    AST_BLANK: assert property ($fell(gate_q) && &calm_q |-> on_q >= 16'h004B)
        else $error("gate pulse ended inside blanking");
    AST_CS: assert property (gate_q && cs_limit && on_q > 16'h0050 |-> ##[1:4] !gate_q)
        else $error("current limit did not end pulse");
    AST_LIGHT: assert property (fb_light_load [*4] |-> !gate_q)
        else $error("gate on under light load");
    AST_PIN: assert property (pin_fault [*4] |-> !gate_q)
        else $error("gate on with pin fault");
    AST_SHUT: assert property (shut |-> !gate_q)
        else $error("gate on while shut down");
    AST_OT_HOLD: assert property ((!supply_off) [*3] ##0 over_temp_latch_q |=> over_temp_latch_q)
        else $error("temperature latch cleared early");
    AST_DELAY: assert property ($rose(overload_protect_q) |-> hold_q >= PROT_LEN)
        else $error("overload tripped too soon");
endmodule
bind flyback_gate_control flyback_gate_chk #(.PW(PW), .PERIOD(PERIOD), .TW(TW),
    .PROT_LEN(PROT_LEN)) chk_i (.*);

// ===== dv/switch_stage.sv
`timescale 1ns/1ns
// ========================================
// Power switch and current sense stand-in
module switch_stage (
    input wire core_clk,
    input wire gate,
    input wire [7:0] trip,
    output reg cs_limit
);
    reg [7:0] n_q = 8'h00;
    initial cs_limit = 1'b0;
    // Primary current ramps only while the switch conducts; trip 0 never limits
    always @(posedge core_clk) begin
        n_q <= gate ? n_q + 8'h01 : 8'h00;
        cs_limit <= gate && trip != 8'h00 && n_q >= trip;
    end
endmodule

// ===== dv/flyback_gate_control_tb_top.sv
`timescale 1ns/1ns
// ========================================
// Bench
module flyback_gate_control_tb_top;
    logic core_clk, arst_n, supply_on, supply_off, supply_ov, pwm_cmp, fb_light_load;
    logic fb_open_loop, out_low, over_temp, fs_short, fs_open, cs_open, fb_short, seen;
    logic [7:0] trip;
    wire cs_limit, gate_q, running_q, ol_q, ov_q, ot_q;
    wire [9:0] cs_ref_q;
    int fail_count, n_compared, cyc, w, i;
    logic [5:0] rows [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
    flyback_gate_control #(.PERIOD(12'h0C8), .SW(10), .SS_LEN(10'h3E8),
        .PROT_LEN(26'h1F4)) dut (.core_clk(core_clk), .arst_n(arst_n),
        .supply_on(supply_on), .supply_off(supply_off), .supply_ov(supply_ov),
        .cs_limit(cs_limit), .pwm_cmp(pwm_cmp), .fb_light_load(fb_light_load),
        .fb_open_loop(fb_open_loop), .out_low(out_low), .over_temp(over_temp),
        .frequency_set_pin_short(fs_short), .frequency_set_pin_open(fs_open),
        .cs_pin_open(cs_open), .fb_pin_short(fb_short), .gate_q(gate_q),
        .running_q(running_q), .cs_ref_q(cs_ref_q), .overload_protect_q(ol_q),
        .supply_overvoltage_protect_q(ov_q), .over_temp_latch_q(ot_q));
    switch_stage load (.core_clk(core_clk), .gate(gate_q), .trip(trip), .cs_limit(cs_limit));
    initial begin
        core_clk = 0;
        forever #2 core_clk = ~core_clk;
    end
    task chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: saw %0h want %0h", $time, s, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task go();
        supply_on = 0;
        tick(3);
        supply_on = 1;
        tick(6);
    endtask
    task off_pulse();
        supply_off = 1;
        tick(8);
        supply_off = 0;
    endtask
    // Width of the next whole gate pulse, in cycles
    task pulse(output int n);
        int k;
        n = 0;
        k = 0;
        while (gate_q !== 1'b0 && k < 999) begin
            tick(1);
            k++;
        end
        while (gate_q !== 1'b1 && k < 999) begin
            tick(1);
            k++;
        end
        while (gate_q === 1'b1 && n < 999) begin
            tick(1);
            n++;
        end
    endtask
    task conclude();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        {arst_n, supply_on, supply_off, supply_ov, pwm_cmp, fb_light_load} = 6'h00;
        {fb_open_loop, out_low, over_temp, fs_short, fs_open, cs_open, fb_short} = 7'h00;
        trip = 8'h00;
        tick(6);
        arst_n = 1;
        tick(2);
        chk({gate_q, running_q, ol_q, ov_q, ot_q}, 16'h0000);
        go();
        chk(running_q, 1);
        pulse(w);
        chk(w >= 75 && w < 150, 1);
        chk(cs_ref_q < 10'h3E8, 1);
        tick(1200);
        chk(cs_ref_q, 16'h03E8);
        pulse(w);
        chk(w >= 148 && w <= 150, 1);
        // ========================================
        // Steady fault rows
        for (i = 0; i < 6; i++) begin
            {fb_light_load, fs_short, fs_open, cs_open, fb_short} = rows[i][4:0];
            tick(20);
            seen = 0;
            repeat (400) begin
                tick(1);
                seen |= gate_q;
            end
            chk(seen, rows[i][5]);
        end
        {fb_light_load, fs_short, fs_open, cs_open, fb_short} = 5'h00;
        supply_off = 1;
        tick(8);
        chk({running_q, gate_q}, 0);
        supply_off = 0;
        go();
        pwm_cmp = 1;
        pulse(w);
        chk(w >= 75 && w <= 78, 1);
        pwm_cmp = 0;
        trip = 8'h64;
        tick(1000);
        pulse(w);
        chk(w >= 100 && w <= 106, 1);
        trip = 8'h00;
        // ========================================
        // Latched shutdowns and restarts
        supply_ov = 1;
        tick(8);
        supply_ov = 0;
        tick(400);
        chk({ov_q, running_q}, 2);
        go();
        chk({ov_q, running_q}, 1);
        over_temp = 1;
        tick(8);
        chk(ot_q, 1);
        go();
        chk(running_q, 0);
        off_pulse();
        go();
        tick(4);
        chk({ot_q, running_q}, 2);
        over_temp = 0;
        off_pulse();
        go();
        chk(running_q, 1);
        fb_open_loop = 1;
        tick(400);
        fb_open_loop = 0;
        tick(10);
        fb_open_loop = 1;
        tick(400);
        chk(ol_q, 0);
        tick(200);
        chk({ol_q, gate_q}, 2);
        fb_open_loop = 0;
        go();
        out_low = 1;
        tick(600);
        chk(ol_q, 1);
        conclude();
    end
endmodule
